// ### hdl/shutdown_pkg.sv
// Package of constants and carriers for the shutdown and de-ghost controller
package shutdown_pkg;

    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int unsigned ROWS      = 4;            // Row switch outputs
    localparam int unsigned COLS      = 18;           // Column sink outputs
    localparam int unsigned PULL_W    = 4;            // Width of one pull selection field
    localparam logic [7:0]  PULL_RST  = 8'h00;        // Pull selection after reset: off
    localparam logic [7:0]  PULL_OFF  = 8'h00;        // Value that disables both pulls
    localparam logic [7:0]  CFG_RST   = 8'h00;        // Configuration after reset
    localparam int unsigned CFG_SSD_POS = 0;          // Soft shutdown bit, low means shut down
    localparam int unsigned ROW_FLD_POS = 4;          // Row pull-down field position
    localparam int unsigned COL_FLD_POS = 0;          // Column pull-up field position

    // ****************************************************************
    // Carriers
    // ****************************************************************
    // Matrix drive request from the scan logic
    typedef struct packed {
        logic [ROWS-1:0] row_on;                      // Row switch driving
        logic [COLS-1:0] col_on;                      // Column sink driving
    } drive_s;

    // Drive and de-ghost pull state presented to the pads
    typedef struct packed {
        logic [ROWS-1:0]   row_switch_out;            // Row switch enable
        logic [COLS-1:0]   column_sink_out;           // Column sink enable
        logic [ROWS-1:0]   row_pull_en;               // Row pull-down connected
        logic [COLS-1:0]   col_pull_en;               // Column pull-up connected
        logic [PULL_W-1:0] row_pull_sel;              // Row pull-down value
        logic [PULL_W-1:0] col_pull_sel;              // Column pull-up value
    } pad_s;

    // Register write port from the serial interface
    typedef struct packed {
        logic       cfg_we;                           // Write configuration register
        logic       pull_we;                          // Write pull selection register
        logic [7:0] wdata;                            // Write data
    } regwr_s;

endpackage

// ### hdl/shutdown_edge_sync.sv
// Two-stage synchroniser for the shutdown pin with rising edge detect
`timescale 1ns/100ps
module shutdown_edge_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pin_n,
    output logic      level,
    output logic      rise
);

    // ****************************************************************
    // Synchroniser
    // ****************************************************************
    logic meta_q;                                     // First stage, read by sync_q only
    logic sync_q;                                     // Second stage, safe to use
    logic prev_q;                                     // Last safe value for edge detect

    // Reset to the pin's idle high level, so leaving reset is never taken
    // for a rising edge; a pin already low shows up two edges after release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= pin_n;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;

endmodule

// ### hdl/deghost_shutdown_ctrl.sv
// Shutdown and de-ghost controller of the LED matrix driver
`timescale 1ns/100ps
// Overview of operation
// - Pulls connect only to outputs that are off
// - Pull values come from pull selection register
// - Zero pull selection disables both pull sets
// - Shutdown pin rising edge resets serial logic
// - Registers keep contents through any shutdown
// - Cleared soft shutdown bit blanks all sinks
// - Register access allowed in software shutdown
// - Low shutdown pin disables all matrix drive
// - High shutdown pin resumes normal operation
// - Registers stay accessible in hardware shutdown
module deghost_shutdown_ctrl (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   shutdown_pin_n,
    input  shutdown_pkg::drive_s        drive_req,
    input  shutdown_pkg::regwr_s        reg_wr,
    output logic [7:0]                  cfg_rd,
    output logic [7:0]                  pull_rd,
    output logic                        serial_reset,
    output logic                        hw_shutdown,
    output logic                        sw_shutdown,
    output shutdown_pkg::pad_s          pads
);

    // ****************************************************************
    // Shutdown pin conditioning
    // ****************************************************************
    logic pin_level;                                  // Synchronised pin level
    logic pin_rise;                                   // One-cycle rising edge

    shutdown_edge_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_n    (shutdown_pin_n),
        .level    (pin_level),
        .rise     (pin_rise)
    );

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] cfg_q;                                // Configuration register
    logic [7:0] cfg_d;
    logic [7:0] pull_q;                               // Pull selection register
    logic [7:0] pull_d;

    // Writes are taken whatever the shutdown state; nothing else alters them
    assign cfg_d  = reg_wr.cfg_we  ? reg_wr.wdata : cfg_q;
    assign pull_d = reg_wr.pull_we ? reg_wr.wdata : pull_q;

    // Only reset clears the registers; shutdown never touches them
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_q  <= shutdown_pkg::CFG_RST;
            pull_q <= shutdown_pkg::PULL_RST;
        end else begin
            cfg_q  <= cfg_d;
            pull_q <= pull_d;
        end
    end

    assign cfg_rd  = cfg_q;
    assign pull_rd = pull_q;

    // ****************************************************************
    // Shutdown decode
    // ****************************************************************
    logic sw_sd;                                      // Software shutdown active
    logic hw_sd;                                      // Hardware shutdown active
    logic drive_ok;                                   // Matrix may be driven
    logic pull_ok;                                    // Pulls may be connected

    assign sw_sd    = ~cfg_q[shutdown_pkg::CFG_SSD_POS];
    assign hw_sd    = ~pin_level;
    assign drive_ok = ~sw_sd & ~hw_sd;
    // Analog off in hardware shutdown, so pulls also off there
    assign pull_ok  = ~hw_sd & (pull_q != shutdown_pkg::PULL_OFF);

    // ****************************************************************
    // Pad outputs
    // ****************************************************************
    shutdown_pkg::pad_s pads_d;                       // Next pad state
    shutdown_pkg::pad_s pads_q;                       // Registered pad state
    logic               serial_reset_q;               // Serial logic reset pulse
    logic               hw_q;
    logic               sw_q;

    always_comb begin
        pads_d.row_switch_out  = drive_ok ? drive_req.row_on : '0;
        pads_d.column_sink_out = drive_ok ? drive_req.col_on : '0;
        // Pull only where the output is not driving
        pads_d.row_pull_en = pull_ok ? ~pads_d.row_switch_out : '0;
        pads_d.col_pull_en = pull_ok ? ~pads_d.column_sink_out : '0;
        pads_d.row_pull_sel =
            pull_q[shutdown_pkg::ROW_FLD_POS +: shutdown_pkg::PULL_W];
        pads_d.col_pull_sel =
            pull_q[shutdown_pkg::COL_FLD_POS +: shutdown_pkg::PULL_W];
    end

    // One register stage so pad data comes from flip-flops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pads_q         <= '0;
            serial_reset_q <= 1'b0;
            hw_q           <= 1'b1;
            sw_q           <= 1'b1;
        end else begin
            pads_q         <= pads_d;
            serial_reset_q <= pin_rise;
            hw_q           <= hw_sd;
            sw_q           <= sw_sd;
        end
    end

    assign pads         = pads_q;
    assign serial_reset = serial_reset_q;
    assign hw_shutdown  = hw_q;
    assign sw_shutdown  = sw_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_rise;
        pin_level && !$past(pin_level);
    endsequence

    property p_serial_reset;
        @(posedge core_clk) disable iff (rst)
        s_rise |=> serial_reset;
    endproperty
    a_serial_reset: assert property (p_serial_reset) else $error("no serial reset on rise");

    property p_reset_only_on_rise;
        @(posedge core_clk) disable iff (rst)
        serial_reset |-> $past(pin_level) && !$past(pin_level, 2);
    endproperty
    a_reset_only_on_rise: assert property (p_reset_only_on_rise) else $error("stray reset");

    property p_row_pull_off_when_on;
        @(posedge core_clk) disable iff (rst)
        (pads.row_pull_en & pads.row_switch_out) == '0;
    endproperty
    a_row_pull_off_when_on: assert property (p_row_pull_off_when_on) else $error("row pull on driven");

    property p_col_pull_off_when_on;
        @(posedge core_clk) disable iff (rst)
        (pads.col_pull_en & pads.column_sink_out) == '0;
    endproperty
    a_col_pull_off_when_on: assert property (p_col_pull_off_when_on) else $error("col pull on driven");

    property p_pull_sel;
        @(posedge core_clk) disable iff (rst)
        ##1 pads.row_pull_sel == $past(pull_q[7:4]) && pads.col_pull_sel == $past(pull_q[3:0]);
    endproperty
    a_pull_sel: assert property (p_pull_sel) else $error("pull value mismatch");

    property p_pull_zero;
        @(posedge core_clk) disable iff (rst)
        pull_q == 8'h00 |=> pads.row_pull_en == '0 && pads.col_pull_en == '0;
    endproperty
    a_pull_zero: assert property (p_pull_zero) else $error("pull on at zero");

    property p_sw_blank;
        @(posedge core_clk) disable iff (rst)
        !cfg_q[0] |=> pads.column_sink_out == '0 && pads.row_switch_out == '0;
    endproperty
    a_sw_blank: assert property (p_sw_blank) else $error("drive in soft shutdown");

    property p_hw_blank;
        @(posedge core_clk) disable iff (rst)
        !pin_level |=> pads.column_sink_out == '0 && hw_shutdown;
    endproperty
    a_hw_blank: assert property (p_hw_blank) else $error("drive in hard shutdown");

    property p_resume;
        @(posedge core_clk) disable iff (rst)
        pin_level && cfg_q[0] |=> pads.column_sink_out == $past(drive_req.col_on);
    endproperty
    a_resume: assert property (p_resume) else $error("drive not resumed");

    property p_write_any_state;
        @(posedge core_clk) disable iff (rst)
        reg_wr.pull_we |=> pull_q == $past(reg_wr.wdata);
    endproperty
    a_write_any_state: assert property (p_write_any_state) else $error("write lost");

    property p_retain;
        @(posedge core_clk) disable iff (rst)
        !reg_wr.cfg_we && !reg_wr.pull_we |=> $stable(cfg_q) && $stable(pull_q);
    endproperty
    a_retain: assert property (p_retain) else $error("register changed");

    // Pin seen low, then high, at two edges in a row
    sequence s_pin_rise;
        shutdown_pin_n && !$past(shutdown_pin_n);
    endsequence

    // Serial reset stands for exactly one cycle
    sequence s_reset_pulse;
        serial_reset ##1 !serial_reset;
    endsequence

    // Two sync stages plus the output flop put the pulse three edges on
    property p_pin_rise_reset;
        @(posedge core_clk) disable iff (rst)
        s_pin_rise |-> ##3 s_reset_pulse;
    endproperty
    a_pin_rise_reset: assert property (p_pin_rise_reset) else $error("late reset");

    // Rows and every pull are dark too while the pin is low
    property p_hw_all_off;
        @(posedge core_clk) disable iff (rst)
        !pin_level |=> pads.row_switch_out == '0 && pads.row_pull_en == '0 &&
            pads.col_pull_en == '0;
    endproperty
    a_hw_all_off: assert property (p_hw_all_off) else $error("pads on at pin low");

    // A high pin clears the hardware shutdown flag one edge later
    property p_hw_clear;
        @(posedge core_clk) disable iff (rst)
        pin_level |=> !hw_shutdown;
    endproperty
    a_hw_clear: assert property (p_hw_clear) else $error("hard flag stuck");

    // Soft shutdown flag follows the inverse of the run bit
    property p_sw_flag;
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> sw_shutdown != $past(cfg_q[shutdown_pkg::CFG_SSD_POS]);
    endproperty
    a_sw_flag: assert property (p_sw_flag) else $error("soft flag wrong");

endmodule

// ### bench/host_model.sv
// Host controller model: register writes and the shutdown pin
`timescale 1ns/100ps
module host_model (
    input  wire logic             core_clk,
    output logic                  shutdown_pin_n,
    output shutdown_pkg::regwr_s  reg_wr
);
    // ****************************************************************
    // Host state
    // ****************************************************************
    logic [7:0] cfg_m;                    // Host copy of configuration
    logic [7:0] pull_m;                   // Host copy of pull selection
    initial begin
        shutdown_pin_n = 1'b1;
        reg_wr         = '0;
        cfg_m          = 8'h00;
        pull_m         = 8'h00;
    end
    // One-cycle write pulse; data is scrambled on release so stale data never looks valid
    task automatic wr(input logic is_cfg, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_wr.cfg_we  = is_cfg;
        reg_wr.pull_we = !is_cfg;
        reg_wr.wdata   = d;
        if (is_cfg) cfg_m = d;
        else pull_m = d;
        @(posedge core_clk);
        #1;
        reg_wr = '{cfg_we: 1'b0, pull_we: 1'b0, wdata: ~d};
    endtask
    // Pin change; never overlaps a write pulse, which has ended by now
    task automatic set_pin(input logic v, input logic polite);
        if (!v && polite) wr(1'b0, 8'h00);
        if (v && !shutdown_pin_n) begin
            wr(1'b1, cfg_m);
            wr(1'b0, pull_m);
        end
        @(posedge core_clk);
        #1;
        shutdown_pin_n = v;
    endtask
endmodule

// ### bench/led_matrix_shutdown_deghost_ctrl_test.sv
// Self-checking bench for the shutdown and de-ghost controller
`timescale 1ns/100ps
module led_matrix_shutdown_deghost_ctrl_test;
    // ****************************************************************
    // Signals and scoreboard
    // ****************************************************************
    typedef struct packed {
        shutdown_pkg::pad_s p;
        logic [7:0]         c;
        logic [7:0]         u;
        logic               h;
        logic               s;
    } note_s;
    logic                 core_clk;
    logic                 rst;
    logic                 obs;            // High for one cycle when a result is due
    logic                 shutdown_pin_n;
    shutdown_pkg::drive_s drive_req;
    shutdown_pkg::regwr_s reg_wr;
    logic [7:0]           cfg_rd;
    logic [7:0]           pull_rd;
    logic                 serial_reset;
    logic                 hw_shutdown;
    logic                 sw_shutdown;
    shutdown_pkg::pad_s   pads;
    int                   err_count;
    int                   check_count;
    note_s                q[$];           // Expected results, oldest first
    note_s                mn;
    host_model host (.core_clk(core_clk), .shutdown_pin_n(shutdown_pin_n), .reg_wr(reg_wr));
    deghost_shutdown_ctrl uut (.core_clk(core_clk), .rst(rst), .shutdown_pin_n(shutdown_pin_n),
        .drive_req(drive_req), .reg_wr(reg_wr), .cfg_rd(cfg_rd), .pull_rd(pull_rd),
        .serial_reset(serial_reset), .hw_shutdown(hw_shutdown), .sw_shutdown(sw_shutdown),
        .pads(pads));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Monitor: compares settled outputs against the oldest note
    always @(negedge core_clk) begin
        if (obs === 1'b1) begin
            mn = q.pop_front();
            check(64'({pads.row_switch_out, pads.column_sink_out}),
                  64'({mn.p.row_switch_out, mn.p.column_sink_out}));
            check(64'({pads.row_pull_en, pads.col_pull_en}),
                  64'({mn.p.row_pull_en, mn.p.col_pull_en}));
            check(64'({pads.row_pull_sel, pads.col_pull_sel}),
                  64'({mn.p.row_pull_sel, mn.p.col_pull_sel}));
            check(64'({cfg_rd, pull_rd}), 64'({mn.c, mn.u}));
            check(64'({hw_shutdown, sw_shutdown}), 64'({mn.h, mn.s}));
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0]           c;
        logic [7:0]           u;
        logic                 pin;
        shutdown_pkg::drive_s d;
        note_s                e;
        int                   k;
        int                   w;
        rst         = 1'b1;
        obs         = 1'b0;
        drive_req   = '0;
        err_count   = 0;
        check_count = 0;
        void'($urandom(6861));
        repeat (12) @(posedge core_clk);
        #1;
        check(64'({cfg_rd, pull_rd, hw_shutdown, sw_shutdown}),
              64'h0000_0000_0000_0003);
        rst = 1'b0;
        $display("test reset_defaults done");
        repeat (4) @(posedge core_clk);
        // Mix of soft shutdown, pin shutdown, pull values and drive patterns
        for (k = 0; k < 48; k++) begin
            c   = 8'($urandom);
            u   = (k % 4 == 0) ? 8'h00 : 8'($urandom);
            pin = (k % 3 != 1);
            d   = 22'($urandom);
            host.wr(1'b1, c);
            host.wr(1'b0, u);
            // Writes land whatever the shutdown state, pin low included
            check(64'({cfg_rd, pull_rd}), 64'({c, u}));
            if (pin !== host.shutdown_pin_n) begin
                if (!pin && k[0]) u = 8'h00;
                host.set_pin(pin, k[0]);
                if (pin) begin
                    // Pulse must come exactly three edges after the rise
                    w = 0;
                    while (serial_reset !== 1'b1 && w < 8) begin
                        @(posedge core_clk);
                        #1;
                        w++;
                    end
                    if (w == 8) begin
                        err_count++;
                        end_sim();
                    end
                    check(64'(w), 64'd3);
                    @(posedge core_clk);
                    #1;
                    check(64'(serial_reset), 64'd0);
                end
            end
            @(posedge core_clk);
            #1;
            drive_req = d;
            repeat (5) @(posedge core_clk);
            #1;
            // Expected outputs worked out from the rules
            e.p.row_switch_out  = (c[0] && pin) ? d.row_on : '0;
            e.p.column_sink_out = (c[0] && pin) ? d.col_on : '0;
            e.p.row_pull_en     = (u != 8'h00 && pin) ? ~e.p.row_switch_out : '0;
            e.p.col_pull_en     = (u != 8'h00 && pin) ? ~e.p.column_sink_out : '0;
            e.p.row_pull_sel    = u[7:4];
            e.p.col_pull_sel    = u[3:0];
            e.c = c;
            e.u = u;
            e.h = !pin;
            e.s = !c[0];
            q.push_back(e);
            obs = 1'b1;
            @(posedge core_clk);
            #1;
            obs = 1'b0;
        end
        @(posedge core_clk);
        $display("test shutdown_mix done");
        end_sim();
    end
endmodule
